// ### common/host_bus_pkg.sv
package host_bus_pkg;

    // ****************************************************************
    // Address modes of the parallel host port
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_NONMUX     = 2'b00,  // Separate address pins and data pins
        MODE_MUX_SINGLE = 2'b01,  // Both address bytes with the low latch strobe
        MODE_MUX_DUAL   = 2'b10   // High then low address byte on bits 7-0
    } addr_mode_t;

    // ****************************************************************
    // Transfer phases
    // ****************************************************************
    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_READ  = 2'b01,
        PH_WRITE = 2'b10
    } phase_t;

    // ****************************************************************
    // Widths, positions, reset values and counts
    // ****************************************************************
    localparam int          BUS_W        = 16;      // Shared data / address bus
    localparam int          ADDR_PIN_W   = 5;       // Non-multiplexed address pins
    localparam int          REG_ADDR_W   = 16;      // Internal register address
    localparam int          BYTE_W       = 8;
    localparam int          LOW_BYTE_LSB = 0;       // Lower byte lane position
    localparam int          HIGH_BYTE_LSB = 8;      // Upper byte lane position
    localparam int          SYNC_DEPTH   = 3;       // Capture stages in each pin synchroniser
    localparam logic [2:0]  SETTLE_CYCLES = 3'h5;   // Pin samples ignored after reset
    localparam logic [15:0] ADDR_RESET   = 16'h0000;
    localparam logic [15:0] DATA_RESET   = 16'h0000;
    localparam logic [15:0] LANE_OFF     = 16'h0000;
    localparam logic [15:0] LANE_LOW     = 16'h00FF; // Byte lanes driven in 8-bit mode
    localparam logic [15:0] LANE_ALL     = 16'hFFFF; // Byte lanes driven in 16-bit mode

endpackage : host_bus_pkg

// ### verilog/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,  // System clock
    input  wire logic             rst,      // Synchronous reset, active high
    input  wire logic [WIDTH-1:0] asyncIn,  // Pin levels, any timing
    output logic      [WIDTH-1:0] syncOut   // Filtered level in ref_clk domain
);

    // ****************************************************************
    // Three-stage capture with agreement filter
    // ****************************************************************
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] syncOut_q;
    logic [WIDTH-1:0] syncOut_d;

    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync: WIDTH must be at least 1");
        end
    end

    // A bit only moves once stages two and three agree; stage one stays private
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            syncOut_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : syncOut_q[i];
        end
    end

    // Registers only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1_q  <= '0;
            stage2_q  <= '0;
            stage3_q  <= '0;
            syncOut_q <= '0;
        end else begin
            stage1_q  <= asyncIn;
            stage2_q  <= stage1_q;
            stage3_q  <= stage2_q;
            syncOut_q <= syncOut_d;
        end
    end

    assign syncOut = syncOut_q;

endmodule : pin_sync

// ### verilog/host_bus_interface.sv
// What this block does
// - Read strobe marks reads, polarity configurable.
// - Direction pin high reads; polarity bit inverts.
// - Enable strobe marks data phase, polarity configurable.
// - Write strobe marks writes, polarity configurable.
// - Respond only while chip select asserted.
// - Five address pins; 16-bit ignores bit 0.
// - Non-multiplexed 8-bit: upper data lanes disabled.
// - Single-phase: both address bytes on low strobe.
// - Dual-phase: high then low byte on 7-0.
// - Dual-phase 8-bit: upper lanes unused, disabled.
// - Address latched on strobe deassert, polarity configurable.
// - Shared bus carries data after address phase.
`timescale 1ns/1ps

module host_bus_interface
    import host_bus_pkg::*;
#(
    parameter int DATA_W = BUS_W,      // Host data bus width
    parameter int APIN_W = ADDR_PIN_W  // Non-multiplexed address pin count
) (
    input  wire logic              ref_clk,           // System clock, 250 MHz
    input  wire logic              rst,               // Synchronous reset, active high
    // Configuration
    input  wire addr_mode_t        addrMode,          // Address mode select
    input  wire logic              wide16,            // 1: 16-bit data, 0: 8-bit data
    input  wire logic              dirEnableMode,     // 1: direction+enable, 0: read+write
    input  wire logic              readPolFlip,       // Inverts read strobe / direction
    input  wire logic              writePolFlip,      // Inverts write / enable strobes
    input  wire logic              selectPolFlip,     // Inverts chip select
    input  wire logic              latchPolFlip,      // Inverts both address latch strobes
    // Host pins
    input  wire logic              readStrobe,        // Read strobe
    input  wire logic              readWrite,         // Direction pin
    input  wire logic              writeStrobe,       // Write strobe
    input  wire logic              data_phase_strobe, // Data phase enable strobe
    input  wire logic              chipSelect,        // Chip select
    input  wire logic [APIN_W-1:0] addrPins,          // Non-multiplexed address
    input  wire logic              addr_latch_high_byte, // High address latch strobe
    input  wire logic              addr_latch_low_byte,  // Low address latch strobe
    input  wire logic [DATA_W-1:0] busIn,             // Data / address bus, pin level
    output logic      [DATA_W-1:0] busOut,            // Data driven on reads
    output logic      [DATA_W-1:0] busOe,             // Per-bit output enable, high drives
    // Register side
    output logic [REG_ADDR_W-1:0]  regAddr,           // Address of current access
    output logic                   regRead,           // One-cycle read request
    input  wire logic [DATA_W-1:0] regRdData,         // Read data, valid with regRead
    output logic                   regWrite,          // One-cycle write commit
    output logic      [DATA_W-1:0] regWrData          // Write data, valid with regWrite
);

    initial begin
        if (DATA_W != BUS_W) begin
            $error("host_bus_interface: DATA_W must be 16");
        end
        if (APIN_W < 1 || APIN_W >= REG_ADDR_W) begin
            $error("host_bus_interface: APIN_W out of range");
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Active-low by default; the flip bit makes it active high
    function automatic logic strobeOn(input logic level, input logic flip);
        return level ^ ~flip;
    endfunction : strobeOn

    // Lanes that carry data for the selected width
    function automatic logic [DATA_W-1:0] laneMask(input logic isWide);
        return isWide ? LANE_ALL : LANE_LOW;
    endfunction : laneMask

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam int CTRL_W = 7;
    logic [CTRL_W-1:0] ctrlS;
    logic [APIN_W-1:0] addrPinsS;
    logic [DATA_W-1:0] busS;

    pin_sync #(.WIDTH(CTRL_W)) ctrlSync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn ({readStrobe, readWrite, writeStrobe, data_phase_strobe,
                   chipSelect, addr_latch_high_byte, addr_latch_low_byte}),
        .syncOut (ctrlS)
    );

    // Address and data share the strobes' latency, so they line up
    pin_sync #(.WIDTH(APIN_W)) addrSync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn (addrPins),
        .syncOut (addrPinsS)
    );

    pin_sync #(.WIDTH(DATA_W)) busSync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn (busIn),
        .syncOut (busS)
    );

    // ****************************************************************
    // Decoded strobe levels
    // ****************************************************************
    logic selected;
    logic readPhase;
    logic writePhase;
    logic dirIsRead;
    logic latchHiOn;
    logic latchLoOn;

    assign selected   = strobeOn(ctrlS[2], selectPolFlip);
    assign dirIsRead  = ctrlS[5] ^ readPolFlip;
    // read strobe, enable strobe with direction
    assign readPhase  = dirEnableMode ? (strobeOn(ctrlS[3], writePolFlip) & dirIsRead)
                                      : strobeOn(ctrlS[6], readPolFlip);
    // write strobe, enable strobe with direction
    assign writePhase = dirEnableMode ? (strobeOn(ctrlS[3], writePolFlip) & ~dirIsRead)
                                      : strobeOn(ctrlS[4], writePolFlip);
    assign latchHiOn  = strobeOn(ctrlS[1], latchPolFlip);
    assign latchLoOn  = strobeOn(ctrlS[0], latchPolFlip);

    // ****************************************************************
    // Startup settle
    // ****************************************************************
    // Synchroniser outputs hold reset zeros first, which look like active strobes
    logic [2:0] settle_q;
    logic [2:0] settle_d;
    logic       ready;

    assign ready = (settle_q == SETTLE_CYCLES);

    always_comb begin
        settle_d = ready ? settle_q : settle_q + 3'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            settle_q <= 3'h0;
        end else begin
            settle_q <= settle_d;
        end
    end

    // ****************************************************************
    // Multiplexed address latches
    // ****************************************************************
    logic [BYTE_W-1:0]     shadowHi_q, shadowHi_d;
    logic [DATA_W-1:0]     shadowLo_q, shadowLo_d;
    logic                  latchHiWas_q, latchHiWas_d;
    logic                  latchLoWas_q, latchLoWas_d;
    logic [REG_ADDR_W-1:0] muxAddr_q, muxAddr_d;
    logic [REG_ADDR_W-1:0] effAddr;

    // Bus is shadowed while a strobe is on, so the edge itself needs no hold time
    always_comb begin
        shadowHi_d   = shadowHi_q;
        shadowLo_d   = shadowLo_q;
        muxAddr_d    = muxAddr_q;
        latchHiWas_d = latchHiOn & ready;
        latchLoWas_d = latchLoOn & ready;
        if (latchHiOn) begin
            shadowHi_d = busS[LOW_BYTE_LSB +: BYTE_W];
        end
        if (latchLoOn) begin
            shadowLo_d = busS;
        end
        unique case (addrMode)
            MODE_MUX_SINGLE: begin
                if (latchLoWas_q && !latchLoOn) begin
                    muxAddr_d = shadowLo_q;
                end
            end
            MODE_MUX_DUAL: begin
                if (latchHiWas_q && !latchHiOn) begin
                    muxAddr_d[HIGH_BYTE_LSB +: BYTE_W] = shadowHi_q;
                end
                if (latchLoWas_q && !latchLoOn) begin
                    muxAddr_d[LOW_BYTE_LSB +: BYTE_W] = shadowLo_q[LOW_BYTE_LSB +: BYTE_W];
                end
            end
            MODE_NONMUX: begin
                muxAddr_d = muxAddr_q;
            end
            default: begin
                muxAddr_d = muxAddr_q;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shadowHi_q   <= '0;
            shadowLo_q   <= '0;
            latchHiWas_q <= 1'b0;
            latchLoWas_q <= 1'b0;
            muxAddr_q    <= ADDR_RESET;
        end else begin
            shadowHi_q   <= shadowHi_d;
            shadowLo_q   <= shadowLo_d;
            latchHiWas_q <= latchHiWas_d;
            latchLoWas_q <= latchLoWas_d;
            muxAddr_q    <= muxAddr_d;
        end
    end

    // Address seen at the start of a transfer
    always_comb begin
        effAddr = muxAddr_q;
        if (addrMode == MODE_NONMUX) begin
            effAddr = {{(REG_ADDR_W-APIN_W){1'b0}}, addrPinsS};
            if (wide16) begin
                effAddr[0] = 1'b0;
            end
        end
    end

    // ****************************************************************
    // Transfer sequencer
    // ****************************************************************
    phase_t                phase_q, phase_d;
    logic [REG_ADDR_W-1:0] regAddr_q, regAddr_d;
    logic                  regRead_q, regRead_d;
    logic                  regWrite_q, regWrite_d;
    logic [DATA_W-1:0]     regWrData_q, regWrData_d;
    logic [DATA_W-1:0]     holdData_q, holdData_d;

    always_comb begin
        phase_d     = phase_q;
        regAddr_d   = regAddr_q;
        regRead_d   = 1'b0;
        regWrite_d  = 1'b0;
        regWrData_d = regWrData_q;
        holdData_d  = holdData_q;
        unique case (phase_q)
            PH_IDLE: begin
                if (ready && selected && readPhase) begin
                    phase_d   = PH_READ;
                    regAddr_d = effAddr;
                    regRead_d = 1'b1;
                end else if (ready && selected && writePhase) begin
                    phase_d   = PH_WRITE;
                    regAddr_d = effAddr;
                end
            end
            PH_READ: begin
                if (!(selected && readPhase)) begin
                    phase_d = PH_IDLE;
                end
            end
            PH_WRITE: begin
                if (writePhase) begin
                    holdData_d = busS & laneMask(wide16);
                end
                if (!selected) begin
                    phase_d = PH_IDLE;
                end else if (!writePhase) begin
                    phase_d     = PH_IDLE;
                    regWrite_d  = 1'b1;
                    regWrData_d = holdData_q;
                end
            end
            default: begin
                phase_d = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_q     <= PH_IDLE;
            regAddr_q   <= ADDR_RESET;
            regRead_q   <= 1'b0;
            regWrite_q  <= 1'b0;
            regWrData_q <= DATA_RESET;
            holdData_q  <= DATA_RESET;
        end else begin
            phase_q     <= phase_d;
            regAddr_q   <= regAddr_d;
            regRead_q   <= regRead_d;
            regWrite_q  <= regWrite_d;
            regWrData_q <= regWrData_d;
            holdData_q  <= holdData_d;
        end
    end

    // ****************************************************************
    // Bus drivers
    // ****************************************************************
    logic [DATA_W-1:0] busOut_q, busOut_d;
    logic [DATA_W-1:0] busOe_q, busOe_d;

    // Driver turns on two cycles after the read request, one cycle after data is loaded
    always_comb begin
        busOut_d = busOut_q;
        busOe_d  = LANE_OFF;
        if (regRead_q) begin
            busOut_d = regRdData & laneMask(wide16);
        end
        if (phase_q == PH_READ && selected && readPhase && !regRead_q) begin
            busOe_d = laneMask(wide16);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busOut_q <= DATA_RESET;
            busOe_q  <= LANE_OFF;
        end else begin
            busOut_q <= busOut_d;
            busOe_q  <= busOe_d;
        end
    end

    assign busOut    = busOut_q;
    assign busOe     = busOe_q;
    assign regAddr   = regAddr_q;
    assign regRead   = regRead_q;
    assign regWrite  = regWrite_q;
    assign regWrData = regWrData_q;

endmodule : host_bus_interface

// ### tb/host_bus_chk.sv
`timescale 1ns/1ps

module host_bus_chk
    import host_bus_pkg::*;
#(
    parameter int DATA_W = BUS_W,     // Data width
    parameter int APIN_W = ADDR_PIN_W // Address pins
) (
    input wire logic                  ref_clk,       // Clock
    input wire logic                  rst,           // Reset
    input wire addr_mode_t            addrMode,      // Address mode
    input wire logic                  wide16,        // 16-bit data
    input wire logic                  selectPolFlip, // Select flip
    input wire logic                  chipSelect,    // Select pin
    input wire logic [DATA_W-1:0]     busOut,        // Read value
    input wire logic [DATA_W-1:0]     busOe,         // Drive enables
    input wire logic [REG_ADDR_W-1:0] regAddr,       // Address
    input wire logic                  regRead,       // Read pulse
    input wire logic [DATA_W-1:0]     regRdData,     // Read data
    input wire logic                  regWrite,      // Write pulse
    input wire logic [DATA_W-1:0]     regWrData      // Write data
);
    logic [3:0]        idleCnt_q;
    logic [3:0]        idleCnt_d;
    logic [DATA_W-1:0] lanes;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Deselected time; saturates so it never wraps to zero
    always_comb begin
        idleCnt_d = idleCnt_q;
        if (chipSelect == selectPolFlip)
            idleCnt_d = 4'h0;
        else if (idleCnt_q != 4'hF)
            idleCnt_d = idleCnt_q + 4'h1;
    end
    always_ff @(posedge ref_clk) begin
        idleCnt_q <= rst ? 4'h0 : idleCnt_d;
    end
    // Lanes legal for the data width
    assign lanes = wide16 ? LANE_ALL : LANE_LOW;

    // ********************
    // Properties
    // ********************
    upper_lanes_a: assert property (!wide16 |-> busOe[15:8] == 8'h00)
        else $error("upper lanes driven in 8-bit mode");
    lane_shape_a: assert property (busOe != LANE_OFF |-> busOe == lanes)
        else $error("partial lane drive");
    read_drive_a: assert property (regRead |=> ##1 busOe == lanes
        && ((busOut ^ $past(regRdData, 2)) & busOe) == LANE_OFF)
        else $error("read data not driven after read pulse");
    read_pulse_a: assert property (regRead |=> !regRead [*3])
        else $error("read pulse too long");
    write_pulse_a: assert property (regWrite |=> !regWrite [*3])
        else $error("write pulse too long");
    write_quiet_a: assert property (regWrite |-> busOe == LANE_OFF && !regRead)
        else $error("bus driven during write");
    desel_quiet_a: assert property (idleCnt_q >= 4'hA
        |-> busOe == LANE_OFF && !regRead && !regWrite)
        else $error("activity while deselected");
    nonmux_addr_a: assert property (addrMode == MODE_NONMUX && (regRead || regWrite)
        |-> (regAddr >> APIN_W) == '0 && !(wide16 && regAddr[0]))
        else $error("bad non-multiplexed address");
    wrdata_hold_a: assert property ($changed(regWrData) |-> regWrite)
        else $error("write data changed without commit");
    wrdata_upper_a: assert property (regWrite && !wide16 |-> regWrData[15:8] == 8'h00)
        else $error("upper write data in 8-bit mode");
endmodule : host_bus_chk

// ### tb/host_model.sv
`timescale 1ns/1ps

module host_model (
    input  wire logic        ref_clk,   // Clock
    input  wire logic        dirEnMode, // Direction+enable signalling
    input  wire logic [3:0]  pol,       // Latch, select, write, read flips
    input  wire logic [15:0] busOut,    // Device value
    input  wire logic [15:0] busOe,     // Device enables
    output logic             rdStb,     // Read strobe
    output logic             dirPin,    // Direction
    output logic             wrStb,     // Write strobe
    output logic             enStb,     // Data phase strobe
    output logic             csPin,     // Chip select
    output logic [4:0]       aPins,     // Address pins
    output logic             latHi,     // High latch
    output logic             latLo,     // Low latch
    output logic [15:0]      busWire    // Resolved bus
);
    logic        csOn = 1'b0;
    logic        rdOn = 1'b0;
    logic        wrOn = 1'b0;
    logic        hiOn = 1'b0;
    logic        loOn = 1'b0;
    logic        isRd = 1'b1;
    logic        hostOe = 1'b0;
    logic [15:0] hostVal = 16'h0000;
    logic [15:0] flt = 16'h3C3C;

    initial aPins = 5'h00;
    assign rdStb = (rdOn && !dirEnMode) ~^ pol[0];
    assign dirPin = isRd ^ pol[0];
    assign wrStb = (wrOn && !dirEnMode) ~^ pol[1];
    assign enStb = ((rdOn || wrOn) && dirEnMode) ~^ pol[1];
    assign csPin = csOn ~^ pol[2];
    assign latHi = hiOn ~^ pol[3];
    assign latLo = loOn ~^ pol[3];
    // released bus toggles so a stale value never passes
    assign busWire = (busOe & busOut) | (~busOe & (hostOe ? hostVal : flt));
    always @(posedge ref_clk) flt <= ~flt;

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    // address phase, junk on unused lanes
    task automatic latchAddr(input logic dual, input logic [15:0] a);
        hostOe = 1'b1;
        hostVal = dual ? {8'hA5, a[15:8]} : a;
        hiOn = dual;
        loOn = !dual;
        step(6);
        hiOn = 1'b0;
        loOn = 1'b0;
        step(3);
        if (dual) begin
            hostVal = {8'h5A, a[7:0]};
            loOn = 1'b1;
            step(6);
            loOn = 1'b0;
            step(3);
        end
        hostOe = 1'b0;
        step(3);
    endtask : latchAddr

    task automatic access(input logic rd, input logic [4:0] a, input logic [15:0] d,
            input logic sel, input logic early, output logic seen, output logic [15:0] got);
        seen = 1'b0;
        got = 16'h0000;
        aPins = a;
        isRd = rd;
        csOn = sel;
        hostOe = !rd;
        hostVal = {8'h5A ^ d[15:8] ^ {8{!rd}}, d[7:0]} ^ (rd ? 16'h0000 : 16'hA500);
        step(1);
        rdOn = rd;
        wrOn = !rd;
        if (rd) begin
            for (int i = 0; i < 20 && !seen; i++) begin
                step(1);
                seen = busOe[0];
            end
            got = busWire;
            rdOn = 1'b0;
            step(3);
        end else if (early) begin
            // Deselect mid-write, well after the write phase has been taken
            step(8);
            csOn = 1'b0;
            step(8);
            wrOn = 1'b0;
        end else begin
            step(8);
            wrOn = 1'b0;
            step(8);
        end
        csOn = 1'b0;
        hostOe = 1'b0;
        step(8);
    endtask : access
endmodule : host_model

// ### tb/tb_top.sv
`timescale 1ns/1ps

module tb_top
    import host_bus_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    addr_mode_t mode = MODE_NONMUX;
    logic w16 = 1'b1;
    logic deMode = 1'b0;
    logic [3:0] pol = 4'h0;
    logic [15:0] rdVal = 16'h0000;
    logic rdStb, dirPin, wrStb, enStb, csPin, latHi, latLo, regRead, regWrite;
    logic [4:0] aPins;
    logic [15:0] busWire, busOut, busOe, regAddr, regWrData, rdAddr, wrAddr, wrData;
    logic [15:0] oeSeen = 16'h0000;
    int rdCnt = 0;
    int wrCnt = 0;
    int testNo = 0;
    int num_errors = 0;
    int total_checks = 0;

    initial forever #2 ref_clk = ~ref_clk;

    host_bus_interface dut (.ref_clk(ref_clk), .rst(rst), .addrMode(mode), .wide16(w16),
        .dirEnableMode(deMode), .readPolFlip(pol[0]), .writePolFlip(pol[1]),
        .selectPolFlip(pol[2]), .latchPolFlip(pol[3]), .readStrobe(rdStb),
        .readWrite(dirPin), .writeStrobe(wrStb), .data_phase_strobe(enStb),
        .chipSelect(csPin), .addrPins(aPins), .addr_latch_high_byte(latHi),
        .addr_latch_low_byte(latLo), .busIn(busWire), .busOut(busOut), .busOe(busOe),
        .regAddr(regAddr), .regRead(regRead), .regRdData(rdVal), .regWrite(regWrite),
        .regWrData(regWrData));
    host_model host (.ref_clk(ref_clk), .dirEnMode(deMode), .pol(pol), .busOut(busOut),
        .busOe(busOe), .rdStb(rdStb), .dirPin(dirPin), .wrStb(wrStb), .enStb(enStb),
        .csPin(csPin), .aPins(aPins), .latHi(latHi), .latLo(latLo), .busWire(busWire));

    // Register side capture and lane usage record
    always @(posedge ref_clk) begin
        if (regRead === 1'b1) begin
            rdCnt <= rdCnt + 1;
            rdAddr <= regAddr;
        end
        if (regWrite === 1'b1) begin
            wrCnt <= wrCnt + 1;
            wrAddr <= regAddr;
            wrData <= regWrData;
        end
        if (!rst)
            oeSeen <= oeSeen | busOe;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic expectEq(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : expectEq

    task automatic run(input addr_mode_t m, input logic w, de, input logic [3:0] p,
            input logic rd, input logic [15:0] a, d, input logic sel, early);
        logic        seen;
        logic [15:0] got;
        logic [15:0] ea;
        logic [15:0] lanes;
        int          nr;
        int          nw;
        mode = m;
        w16 = w;
        deMode = de;
        rdVal = d;
        // Select flip last, so decode transients never meet a live strobe
        pol = {p[3], pol[2], p[1:0]};
        step(8);
        pol = p;
        step(8);
        if (m != MODE_NONMUX)
            host.latchAddr(m == MODE_MUX_DUAL, a);
        nr = rdCnt;
        nw = wrCnt;
        oeSeen = 16'h0000;
        host.access(rd, a[4:0], d, sel, early, seen, got);
        lanes = w ? LANE_ALL : LANE_LOW;
        ea = (m == MODE_NONMUX) ? {11'h000, a[4:1], a[0] & !w} : a;
        testNo++;
        expectEq(16'(rdCnt - nr), {15'h0, rd & sel}, "reads");
        expectEq({15'h0, seen}, {15'h0, rd & sel}, "drive seen");
        expectEq(16'(wrCnt - nw), {15'h0, !rd & sel & !early}, "writes");
        expectEq(oeSeen, (rd & sel) ? lanes : LANE_OFF, "lanes");
        if (rd & sel) begin
            expectEq(rdAddr, ea, "read address");
            expectEq(got & lanes, d & lanes, "read data");
        end
        if (!rd & sel & !early) begin
            expectEq(wrAddr, ea, "write address");
            expectEq(wrData, w ? d : {8'h00, d[7:0]}, "write data");
        end
        $display("test %0d done", testNo);
    endtask : run

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // Transfers across every mode and width, with polarity sets 0, 4, 7, 8 and F
    initial begin
        step(10);
        rst = 1'b0;
        step(8);
        run(MODE_NONMUX, 1, 0, 4'h0, 1, 16'h0013, 16'hBEEF, 1, 0);
        run(MODE_NONMUX, 1, 0, 4'h0, 0, 16'h0007, 16'h1234, 1, 0);
        run(MODE_NONMUX, 0, 0, 4'h0, 1, 16'h0013, 16'hC3A5, 1, 0);
        run(MODE_NONMUX, 0, 0, 4'h0, 0, 16'h0009, 16'h7E81, 1, 0);
        run(MODE_NONMUX, 1, 1, 4'h0, 1, 16'h001E, 16'h0F0F, 1, 0);
        run(MODE_NONMUX, 1, 1, 4'h0, 0, 16'h0002, 16'hF00D, 1, 0);
        run(MODE_NONMUX, 1, 1, 4'h7, 1, 16'h0005, 16'h5555, 1, 0);
        run(MODE_NONMUX, 1, 0, 4'h7, 0, 16'h0011, 16'hAAAA, 1, 0);
        run(MODE_MUX_SINGLE, 1, 0, 4'h8, 0, 16'hA55A, 16'h6789, 1, 0);
        run(MODE_MUX_SINGLE, 1, 0, 4'h0, 1, 16'h3C01, 16'h9ABC, 1, 0);
        run(MODE_MUX_DUAL, 0, 0, 4'h0, 1, 16'h1234, 16'h00C7, 1, 0);
        run(MODE_MUX_DUAL, 0, 1, 4'hF, 0, 16'h8E71, 16'h4455, 1, 0);
        run(MODE_NONMUX, 1, 0, 4'h0, 1, 16'h0001, 16'h1111, 0, 0);
        run(MODE_NONMUX, 1, 0, 4'h4, 0, 16'h0003, 16'h2222, 0, 0);
        run(MODE_NONMUX, 1, 0, 4'h0, 0, 16'h0004, 16'h3333, 1, 1);
        conclude();
    end
endmodule : tb_top

bind host_bus_interface host_bus_chk #(.DATA_W(DATA_W), .APIN_W(APIN_W)) chk (
    .ref_clk(ref_clk), .rst(rst), .addrMode(addrMode), .wide16(wide16),
    .selectPolFlip(selectPolFlip), .chipSelect(chipSelect), .busOut(busOut), .busOe(busOe),
    .regAddr(regAddr), .regRead(regRead), .regRdData(regRdData), .regWrite(regWrite),
    .regWrData(regWrData));
